// *** sim/esie_mem_model.sv ***
`timescale 1ns/100ps
`default_nettype none

// ------------------------------------------------------------
// byte-wide data memory seen by the executer
// ------------------------------------------------------------
module esie_mem_model (
  input  wire logic        clk,
  input  wire logic [11:0] mem_addr,
  input  wire logic        mem_rd,
  output logic      [7:0]  mem_rdata,
  input  wire logic        mem_wr,
  input  wire logic [7:0]  mem_wdata
);
  logic [7:0] mem [0:4095];
  logic [7:0] last;

  // fixed pattern so every source byte is predictable
  initial begin
    for (int a = 0; a < 4096; a++) begin
      mem[a] = 8'(a) ^ 8'hA5;
    end
    last = 8'h00;
  end

  // write port, plus the last byte handed out
  always @(posedge clk) begin
    if (mem_wr) begin
      mem[mem_addr] <= mem_wdata;
    end
    if (mem_rd) begin
      last <= mem[mem_addr];
    end
  end

  // released read bus shows the inverse of the last byte
  assign mem_rdata = mem_rd ? mem[mem_addr] : ~last;
endmodule

`default_nettype wire

// *** sim/extended_stack_instruction_exec_test.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "esie_defs.svh"

module extended_stack_instruction_exec_test;
  localparam int PC_W = 21;
  logic clk, rst_b, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, instr_valid, instr_ack, pc_load;
  logic mem_rd, mem_wr, std_valid, std_dest_file;
  logic [7:0] s_axi_awaddr, s_axi_araddr, mem_rdata, mem_wdata, o;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd, seed, q[$];
  logic [3:0] s_axi_wstrb, bank_select_reg;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr, br;
  logic [15:0] instr_word;
  logic [PC_W-1:0] return_stack_top, pc_value;
  logic [11:0] mem_addr, std_addr, fp, p;
  logic [5:0] k, k2;
  int n_fail, n_compared;

  esie_exec #(.PC_W(PC_W)) esie_exec_i (.clk, .rst_b, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .instr_valid, .instr_word, .instr_ack, .bank_select_reg, .return_stack_top, .pc_load, .pc_value,
    .mem_addr, .mem_rd, .mem_rdata, .mem_wr, .mem_wdata, .std_valid, .std_addr, .std_dest_file);
  esie_mem_model esie_mem_model_i (.clk, .mem_addr, .mem_rd, .mem_rdata, .mem_wr, .mem_wdata);

  // ------------------------------------------------------------
  // checking and bus tasks
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic complete_run;
    if (n_fail == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic bwr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    br = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic brd(input logic [7:0] a);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    brd(a);
    chk("register", rd, exp);
  endtask

  // word held until acknowledged; valid dropped only by idle
  task automatic ins(input logic [15:0] w);
    instr_word <= w;
    instr_valid <= 1'b1;
    do @(posedge clk); while (!instr_ack);
  endtask

  task automatic idle;
    instr_valid <= 1'b0;
  endtask

  // standard instruction with its expected effective address
  task automatic std(input logic ext, input logic bitop, input logic [7:0] f);
    logic a, d;
    logic [3:0] b;
    logic [11:0] ea;
    a = 1'($random(seed));
    d = bitop | 1'($random(seed));
    b = 4'($random(seed));
    if (a) ea = {b, f};
    else if (ext && f <= 8'h5F) ea = fp + {4'h0, f};
    else ea = {(f <= 8'h5F) ? 4'h0 : 4'hF, f};
    bank_select_reg <= b;
    q.push_back({4'h2, 15'h0, ea, d});
    ins(bitop ? {4'h8, b[3:2], d, a, f} : {6'h09, d, a, f});
  endtask

  task automatic mov(input logic [11:0] pv, input logic [6:0] zs, input logic [6:0] zd, input logic ws,
                     input logic wd);
    logic [11:0] sa;
    bwr(`ESIE_OFS_PTR2, {20'h0, pv});
    sa = pv + {5'h0, zs};
    if (wd) q.push_back({4'h1, 8'h00, 12'(pv + {5'h0, zd}), ws ? (sa[7:0] ^ 8'hA5) : 8'h00});
    ins({`ESIE_OP_MOVE1, zs});
    ins({`ESIE_OP_MOVE2, 5'($random(seed)), zd});
    idle;
  endtask

  // every result seen at the ports is matched to the oldest note
  task automatic see(input logic [31:0] r);
    if (q.size() == 0) chk("result", r, 32'hFFFFFFFF);
    else chk("result", r, q.pop_front());
  endtask

  always @(posedge clk) begin
    if (rst_b) begin
      if (mem_wr) see({4'h1, 8'h00, mem_addr, mem_wdata});
      if (std_valid) see({4'h2, 15'h0, std_addr, std_dest_file});
      if (pc_load) see({4'h3, 7'h0, pc_value});
    end
  end

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // hang guard
  initial begin
    repeat (6000) @(posedge clk);
    n_fail++;
    complete_run;
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    seed = 32'h6275AC2C;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, instr_valid} = 6'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, instr_word, bank_select_reg} = 68'h0;
    s_axi_wstrb = 4'hF;
    return_stack_top = '0;
    n_fail = 0;
    n_compared = 0;
    rst_b = 1'b0;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    rchk(`ESIE_OFS_CTRL, 32'h0);
    rchk(`ESIE_OFS_PTR2, 32'h0);
    brd(8'h14);
    chk("rresp", {30'h0, rr}, {30'h0, `ESIE_RESP_SLVERR});
    bwr(8'h14, 32'h0);
    chk("bresp", {30'h0, br}, {30'h0, `ESIE_RESP_SLVERR});
    for (int e = 0; e < 2; e++) begin
      fp = 12'($random(seed));
      bwr(`ESIE_OFS_CTRL, 32'(e));
      bwr(`ESIE_OFS_PTR2, {20'h0, fp});
      for (int i = 0; i < 8; i++) begin
        std(e[0], i[0], (i == 0) ? 8'h5F : (i == 1) ? 8'h60 : 8'($random(seed)));
      end
      // push opcode while disabled runs as a plain standard operand
      if (e == 0) begin
        q.push_back({4'h2, 15'h0, 12'hFFA, 1'b1});
        ins(16'hFAFA);
      end
      idle;
    end
    k2 = 6'($random(seed));
    bwr(`ESIE_OFS_PTR2, 32'h0);
    q.push_back({4'h1, 8'h00, 12'h000, 2'h0, k2});
    ins({`ESIE_OP_PUSH, 2'h0, k2});
    idle;
    rchk(`ESIE_OFS_PTR2, 32'hFFF);
    mov(12'h080, 7'h05, 7'h06, 1'b1, 1'b1);
    mov(12'hFC0, 7'h7F, 7'h50, 1'b1, 1'b1);
    mov(12'hF70, 7'h7F, 7'h01, 1'b0, 1'b1);
    mov(12'hF70, 7'h00, 7'h77, 1'b1, 1'b0);
    for (int s = 0; s < 4; s++) begin
      p = 12'($random(seed));
      k = 6'($random(seed));
      k2 = 6'($random(seed));
      o = 8'h04 + {4'h0, (s == 3) ? 2'h2 : 2'(s), 2'h0};
      return_stack_top <= PC_W'($random(seed));
      bwr(o, {20'h0, p});
      if (s == 3) q.push_back({4'h3, 7'h0, return_stack_top});
      ins({`ESIE_OP_SUB, 2'(s), k});
      idle;
      rchk(o, {20'h0, 12'(p - {6'h0, k})});
      if (s == 3) q.push_back({4'h3, 7'h0, return_stack_top});
      ins({`ESIE_OP_ADD, 2'(s), k2});
      idle;
      rchk(o, {20'h0, 12'(p - {6'h0, k} + {6'h0, k2})});
    end
    chk("pending", 32'(q.size()), 32'h0);
    complete_run;
  end
endmodule

`default_nettype wire

// *** src/esie_addr_resolve.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "esie_defs.svh"

module esie_addr_resolve (
  input  wire logic               ext_en,
  input  wire logic               access_bit,
  input  wire logic [7:0]         file_addr,
  input  wire logic [3:0]         bank,
  input  wire esie_pkg::esie_addr_t fp,
  output esie_pkg::esie_addr_t    eff_addr
);

  // ----------------------------------------------------------------
  // effective address of a byte or bit operand
  // ----------------------------------------------------------------
  always_comb begin
    if (access_bit) begin
      eff_addr = {bank, file_addr};  // banked access keeps literal meaning
    end else if (ext_en && (file_addr <= `ESIE_OFFSET_MAX)) begin
      eff_addr = fp + {4'h0, file_addr};  // offset from frame pointer
    end else if (file_addr <= `ESIE_OFFSET_MAX) begin
      eff_addr = {`ESIE_ACC_LOW, file_addr};
    end else begin
      eff_addr = {`ESIE_ACC_HIGH, file_addr};
    end
  end

endmodule
`default_nettype wire

// *** src/esie_defs.svh ***
`ifndef ESIE_DEFS_SVH
`define ESIE_DEFS_SVH

// ----------------------------------------------------------------
// register map (byte addresses)
// ----------------------------------------------------------------
`define ESIE_OFS_CTRL      8'h00
`define ESIE_OFS_PTR0      8'h04
`define ESIE_OFS_PTR1      8'h08
`define ESIE_OFS_PTR2      8'h0C
`define ESIE_OFS_STATUS    8'h10
`define ESIE_CTRL_EXT_BIT  0
`define ESIE_CTRL_RST      1'h0
`define ESIE_PTR_RST       12'h000

// ----------------------------------------------------------------
// bus answers
// ----------------------------------------------------------------
`define ESIE_RESP_OKAY     2'h0
`define ESIE_RESP_SLVERR   2'h2

// ----------------------------------------------------------------
// opcodes and phases
// ----------------------------------------------------------------
`define ESIE_OP_MOVE1      9'h1D7
`define ESIE_OP_MOVE2      4'hF
`define ESIE_OP_PUSH       8'hFA
`define ESIE_OP_SUB        8'hE9
`define ESIE_OP_ADD        8'hE8
`define ESIE_SEL_FP        2'h2
`define ESIE_SEL_RET       2'h3
`define ESIE_PH_DECODE     2'h0
`define ESIE_PH_READ       2'h1
`define ESIE_PH_PROC       2'h2
`define ESIE_PH_WRITE      2'h3

// ----------------------------------------------------------------
// addressing
// ----------------------------------------------------------------
`define ESIE_OFFSET_MAX    8'h5F
`define ESIE_ACC_HIGH      4'hF
`define ESIE_ACC_LOW       4'h0
`define ESIE_IND0          12'hFEF
`define ESIE_IND1          12'hFE7
`define ESIE_IND2          12'hFDF
`define ESIE_IND_SPAN      12'h004

`endif

// *** src/esie_exec.sv ***
// Behaviour
// - indexed move copies fp+src to fp+dst
// - move is two words, two cycles
// - move addresses span whole 4096-byte space
// - indirect source reads as 00h
// - indirect destination makes move a no-op
// - push writes literal at fp, decrements fp
// - subtract literal from selected pointer, one cycle
// - select 11 subtracts from fp, returns, two cycles
// - enable also turns on offset addressing
// - disabled: access bit picks access or bank
// - enabled, access 0, f<=5Fh: fp plus offset
// - other addresses keep literal meaning
// - offset rule covers all access-bit instructions
// - destination bit keeps its normal meaning
// - enable bit resets to zero, disabling both
// - add literal to pointer, 11 also returns
`timescale 1ns/100ps
`default_nettype none
`include "esie_defs.svh"

module esie_exec #(
  parameter int PC_W = 21
) (
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic [7:0]       s_axi_awaddr,
  input  wire logic             s_axi_awvalid,
  output logic                  s_axi_awready,
  input  wire logic [31:0]      s_axi_wdata,
  input  wire logic [3:0]       s_axi_wstrb,
  input  wire logic             s_axi_wvalid,
  output logic                  s_axi_wready,
  output logic [1:0]            s_axi_bresp,
  output logic                  s_axi_bvalid,
  input  wire logic             s_axi_bready,
  input  wire logic [7:0]       s_axi_araddr,
  input  wire logic             s_axi_arvalid,
  output logic                  s_axi_arready,
  output logic [31:0]           s_axi_rdata,
  output logic [1:0]            s_axi_rresp,
  output logic                  s_axi_rvalid,
  input  wire logic             s_axi_rready,
  input  wire logic             instr_valid,
  input  wire logic [15:0]      instr_word,
  output logic                  instr_ack,
  input  wire logic [3:0]       bank_select_reg,
  input  wire logic [PC_W-1:0]  return_stack_top,
  output logic                  pc_load,
  output logic [PC_W-1:0]       pc_value,
  output logic [11:0]           mem_addr,
  output logic                  mem_rd,
  input  wire logic [7:0]       mem_rdata,
  output logic                  mem_wr,
  output logic [7:0]            mem_wdata,
  output logic                  std_valid,
  output logic [11:0]           std_addr,
  output logic                  std_dest_file
);

  initial begin
    if (PC_W < 1 || PC_W > 32) $error("PC_W out of range");
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic                  extended_set_enable;
  esie_pkg::esie_addr_t  ptr [3];
  logic [1:0]            phase;
  esie_pkg::esie_state_e state;
  logic [15:0]           cur_word;
  logic                  taken;
  logic [11:0]           move_addr;
  logic [7:0]            move_data;
  logic                  aw_held;
  logic                  w_held;
  logic [7:0]            aw_addr;
  logic [31:0]           w_data;
  logic [3:0]            w_strb;
  logic                  wr_fire;
  logic                  is_move;
  logic                  is_push;
  logic                  is_sub;
  logic                  is_add;
  logic [1:0]            sel;
  logic [11:0]           next_ptr;
  logic [11:0]           std_eff;

  // indirect-register detection, used by both move cycles
  function automatic logic is_indirect(input logic [11:0] a);
    is_indirect = (a <= `ESIE_IND0 && a > `ESIE_IND0 - `ESIE_IND_SPAN - 12'h001)
               || (a <= `ESIE_IND1 && a > `ESIE_IND1 - `ESIE_IND_SPAN - 12'h001)
               || (a <= `ESIE_IND2 && a > `ESIE_IND2 - `ESIE_IND_SPAN - 12'h001);
  endfunction

  // byte-lane merge for a 12-bit register
  function automatic logic [11:0] merge12(input logic [11:0] old, input logic [31:0] d, input logic [3:0] s);
    merge12 = {s[1] ? d[11:8] : old[11:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  // extended opcodes gated by enable
  assign is_move = extended_set_enable && (cur_word[15:7] == `ESIE_OP_MOVE1);
  assign is_push = extended_set_enable && (cur_word[15:8] == `ESIE_OP_PUSH);
  assign is_sub  = extended_set_enable && (cur_word[15:8] == `ESIE_OP_SUB);
  assign is_add  = extended_set_enable && (cur_word[15:8] == `ESIE_OP_ADD);
  assign sel     = cur_word[7:6];
  assign wr_fire = aw_held && w_held && !s_axi_bvalid;

  // pointer result of add or subtract; select 11 always works on fp
  // wraps modulo 4096
  always_comb begin
    logic [11:0] base;
    base = ptr[(sel == `ESIE_SEL_RET) ? `ESIE_SEL_FP : sel];
    if (is_sub) begin
      next_ptr = base - {6'h00, cur_word[5:0]};
    end else begin
      next_ptr = base + {6'h00, cur_word[5:0]};
    end
  end

  // every standard operand goes through one resolver
  esie_addr_resolve u_resolve (
    .ext_en     (extended_set_enable),
    .access_bit (cur_word[8]),
    .file_addr  (cur_word[7:0]),
    .bank       (bank_select_reg),
    .fp         (ptr[2]),
    .eff_addr   (std_eff)
  );

  // ----------------------------------------------------------------
  // phase counter
  // ----------------------------------------------------------------
  // four phases per cycle
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      phase <= `ESIE_PH_DECODE;
    end else begin
      phase <= phase + 2'h1;
    end
  end

  // ----------------------------------------------------------------
  // word capture and sequencing
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state     <= esie_pkg::ST_RUN;
      cur_word  <= 16'h0000;
      taken     <= 1'b0;
      instr_ack <= 1'b0;
    end else begin
      instr_ack <= 1'b0;
      if (phase == `ESIE_PH_DECODE) begin
        taken <= instr_valid && (state != esie_pkg::ST_NOP);
        if (instr_valid && state == esie_pkg::ST_RUN) begin
          cur_word <= instr_word;
        end
      end
      if (phase == `ESIE_PH_PROC) begin
        instr_ack <= taken;
      end
      if (phase == `ESIE_PH_WRITE) begin
        unique case (state)
          esie_pkg::ST_RUN: begin
            if (taken && is_move) begin
              state <= esie_pkg::ST_MOVE2;
            // return costs a second, empty cycle
            end else if (taken && (is_sub || is_add) && sel == `ESIE_SEL_RET) begin
              state <= esie_pkg::ST_NOP;
            end
          end
          esie_pkg::ST_MOVE2: begin
            if (taken) begin
              state <= esie_pkg::ST_RUN;
            end
          end
          esie_pkg::ST_NOP:   state <= esie_pkg::ST_RUN;
          default:            state <= esie_pkg::ST_RUN;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // data memory port
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mem_addr  <= 12'h000;
      mem_rd    <= 1'b0;
      mem_wr    <= 1'b0;
      mem_wdata <= 8'h00;
      move_addr <= 12'h000;
      move_data <= 8'h00;
    end else begin
      mem_rd <= 1'b0;
      mem_wr <= 1'b0;
      if (phase == `ESIE_PH_READ && taken) begin
        move_addr <= ptr[2] + {5'h00, (state == esie_pkg::ST_MOVE2) ? instr_word[6:0] : cur_word[6:0]};
      end
      if (phase == `ESIE_PH_PROC && taken && state == esie_pkg::ST_RUN) begin
        if (is_move && !is_indirect(move_addr)) begin
          mem_rd   <= 1'b1;
          mem_addr <= move_addr;
        end
        if (is_push) begin
          mem_wr    <= 1'b1;
          mem_addr  <= ptr[2];
          mem_wdata <= cur_word[7:0];
        end
      end
      // source byte sampled in last phase
      if (phase == `ESIE_PH_WRITE && taken && state == esie_pkg::ST_RUN && is_move) begin
        move_data <= mem_rd ? mem_rdata : 8'h00;
      end
      if (phase == `ESIE_PH_PROC && taken && state == esie_pkg::ST_MOVE2 &&
          instr_word[15:12] == `ESIE_OP_MOVE2 && !is_indirect(move_addr)) begin
        mem_wr    <= 1'b1;
        mem_addr  <= move_addr;
        mem_wdata <= move_data;
      end
    end
  end

  // ----------------------------------------------------------------
  // pointers and return
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ptr[0]   <= `ESIE_PTR_RST;
      ptr[1]   <= `ESIE_PTR_RST;
      ptr[2]   <= `ESIE_PTR_RST;
      pc_load  <= 1'b0;
      pc_value <= '0;
    end else begin
      pc_load <= 1'b0;
      if (phase == `ESIE_PH_WRITE && taken && state == esie_pkg::ST_RUN && is_push) begin
        ptr[2] <= ptr[2] - 12'h001;
      end else if (phase == `ESIE_PH_WRITE && taken && state == esie_pkg::ST_RUN && (is_sub || is_add)) begin
        ptr[(sel == `ESIE_SEL_RET) ? `ESIE_SEL_FP : sel] <= next_ptr;
        if (sel == `ESIE_SEL_RET) begin
          pc_load  <= 1'b1;
          pc_value <= return_stack_top;
        end
      end else if (wr_fire) begin
        if (aw_addr == `ESIE_OFS_PTR0) ptr[0] <= merge12(ptr[0], w_data, w_strb);
        if (aw_addr == `ESIE_OFS_PTR1) ptr[1] <= merge12(ptr[1], w_data, w_strb);
        if (aw_addr == `ESIE_OFS_PTR2) ptr[2] <= merge12(ptr[2], w_data, w_strb);
      end
    end
  end

  // ----------------------------------------------------------------
  // standard operand address
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      std_valid     <= 1'b0;
      std_addr      <= 12'h000;
      std_dest_file <= 1'b0;
    end else begin
      std_valid <= 1'b0;
      // resolved address issued in read phase
      if (phase == `ESIE_PH_READ && taken && state == esie_pkg::ST_RUN &&
          !(is_move || is_push || is_sub || is_add)) begin
        std_valid     <= 1'b1;
        std_addr      <= std_eff;
        std_dest_file <= cur_word[9];
      end
    end
  end

  // ----------------------------------------------------------------
  // bus write channels
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `ESIE_RESP_OKAY;
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= 8'h00;
      w_data        <= 32'h0000_0000;
      w_strb        <= 4'h0;
    end else begin
      s_axi_awready <= s_axi_awvalid && !s_axi_awready && !aw_held && !s_axi_bvalid;
      s_axi_wready  <= s_axi_wvalid && !s_axi_wready && !w_held && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr == `ESIE_OFS_CTRL || aw_addr == `ESIE_OFS_PTR0 ||
                         aw_addr == `ESIE_OFS_PTR1 || aw_addr == `ESIE_OFS_PTR2 ||
                         aw_addr == `ESIE_OFS_STATUS) ? `ESIE_RESP_OKAY : `ESIE_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      extended_set_enable <= `ESIE_CTRL_RST;
    end else if (wr_fire && aw_addr == `ESIE_OFS_CTRL && w_strb[0]) begin
      extended_set_enable <= w_data[`ESIE_CTRL_EXT_BIT];
    end
  end

  // ----------------------------------------------------------------
  // bus read channel
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `ESIE_RESP_OKAY;
    end else begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `ESIE_RESP_OKAY;
        unique case (s_axi_araddr)
          `ESIE_OFS_CTRL:   s_axi_rdata <= {31'h0000_0000, extended_set_enable};
          `ESIE_OFS_PTR0:   s_axi_rdata <= {20'h00000, ptr[0]};
          `ESIE_OFS_PTR1:   s_axi_rdata <= {20'h00000, ptr[1]};
          `ESIE_OFS_PTR2:   s_axi_rdata <= {20'h00000, ptr[2]};
          `ESIE_OFS_STATUS: s_axi_rdata <= {27'h000_0000, taken, state, phase};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `ESIE_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  phase_wrap_a: assert property (@(posedge clk) disable iff (!rst_b)
    phase == `ESIE_PH_WRITE |=> phase == `ESIE_PH_DECODE)
    else $error("phase did not wrap");

  push_store_a: assert property (@(posedge clk) disable iff (!rst_b)
    (phase == `ESIE_PH_PROC && taken && state == esie_pkg::ST_RUN && is_push)
    |=> mem_wr && mem_addr == $past(ptr[2]) && mem_wdata == $past(cur_word[7:0]) ##1 ptr[2] == $past(ptr[2], 2) - 12'h001)
    else $error("push store or decrement wrong");

  sub_ptr_a: assert property (@(posedge clk) disable iff (!rst_b)
    (phase == `ESIE_PH_WRITE && taken && state == esie_pkg::ST_RUN && is_sub && sel == 2'h0)
    |=> ptr[0] == $past(ptr[0]) - {6'h00, $past(cur_word[5:0])})
    else $error("subtract from pointer wrong");

  ret_cycle_a: assert property (@(posedge clk) disable iff (!rst_b)
    pc_load |-> state == esie_pkg::ST_NOP ##4 state == esie_pkg::ST_RUN)
    else $error("return not followed by one empty cycle");

  move_two_a: assert property (@(posedge clk) disable iff (!rst_b)
    (phase == `ESIE_PH_WRITE && taken && state == esie_pkg::ST_RUN && is_move)
    |=> state == esie_pkg::ST_MOVE2)
    else $error("move did not take a second word");

  src_zero_a: assert property (@(posedge clk) disable iff (!rst_b)
    (phase == `ESIE_PH_PROC && taken && state == esie_pkg::ST_RUN && is_move && is_indirect(move_addr))
    |=> !mem_rd ##1 move_data == 8'h00)
    else $error("indirect source not read as zero");

  dst_nop_a: assert property (@(posedge clk) disable iff (!rst_b)
    (mem_wr && state == esie_pkg::ST_MOVE2) |-> !is_indirect(mem_addr))
    else $error("write to indirect destination");

  std_off_a: assert property (@(posedge clk) disable iff (!rst_b)
    (phase == `ESIE_PH_READ && taken && state == esie_pkg::ST_RUN && extended_set_enable &&
     !(is_move || is_push || is_sub || is_add) && !cur_word[8] && cur_word[7:0] <= `ESIE_OFFSET_MAX)
    |=> std_valid && std_addr == $past(ptr[2]) + {4'h0, $past(cur_word[7:0])})
    else $error("offset address not frame relative");

  ext_off_a: assert property (@(posedge clk) disable iff (!rst_b)
    (phase == `ESIE_PH_READ && taken && state == esie_pkg::ST_RUN && !extended_set_enable) |=> std_valid)
    else $error("disabled opcode not handled as standard");

endmodule
`default_nettype wire

// *** src/esie_pkg.sv ***
package esie_pkg;
  // instruction sequencer states
  typedef enum logic [1:0] {
    ST_RUN   = 2'b00,
    ST_MOVE2 = 2'b01,
    ST_NOP   = 2'b10
  } esie_state_e;

  typedef logic [11:0] esie_addr_t;
endpackage
